//--- core/ssm_pkg.sv
// Purpose: shared constants for the single-shot mirror register block
// Assumes: byte-wide register port, addresses as printed
// Notes:   mirror window 0xC0..0xCD aliases scattered primary registers
package ssm_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          NUM_REGS        = 256;
    // mirror window
    localparam logic [7:0]  MIR_BASE        = 8'hC0;
    localparam logic [7:0]  MIR_LAST        = 8'hCD;
    // mirror addresses, then primary addresses
    localparam logic [7:0]  ADR_RSVD_C0     = 8'hC0;
    localparam logic [7:0]  ADR_CAL_FLAGS   = 8'hC1;
    localparam logic [7:0]  ADR_RSVD_C2     = 8'hC2;
    localparam logic [7:0]  ADR_TRIGGER     = 8'hC3;
    localparam logic [7:0]  ADR_HOURS_HI    = 8'hC4;
    localparam logic [7:0]  ADR_HOURS_LO    = 8'hC5;
    localparam logic [7:0]  ADR_PRIM_C0     = 8'h80;
    localparam logic [7:0]  ADR_PRIM_C1     = 8'h81;
    localparam logic [7:0]  ADR_PRIM_C2     = 8'h92;
    localparam logic [7:0]  ADR_PRIM_C3     = 8'h93;
    localparam logic [7:0]  ADR_PRIM_C4     = 8'h88;
    localparam logic [7:0]  ADR_TARGET_LO   = 8'hB1;
    // calibration flag bits
    localparam int          CAL_BIT_FACTORY = 2;
    localparam int          CAL_BIT_BASE    = 3;
    localparam int          CAL_BIT_TARGET  = 4;
    localparam int          CAL_BIT_BACKGND = 5;
    localparam int          CAL_BIT_ZERO    = 6;
    localparam int          CAL_KINDS       = 5;
    localparam logic [7:0]  CAL_FLAG_MASK   = 8'h7C;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam logic [15:0] HOURS_RESET     = 16'h0000;
endpackage

//--- core/ssm_regs.sv
// Purpose: mirror window, calibration flags, single-shot trigger, hours counter
// Assumes: byte register port synchronous to clk_sys; read data one cycle later
// Notes:   other registers live in the shared byte store
//
// Behaviour
// - addresses 0xC0..0xCD reach the same storage as their scattered primaries
// - successful calibration sets its flag bit, bits 2 through 6
// - trigger write starts one measurement only in single measurement mode
// - sixteen-bit hours-since-baseline register, upper byte at 0xC4
`timescale 1ns/10ps
module ssm_regs
    import ssm_pkg::*;
#(
    parameter int AW = ssm_pkg::ADDR_W,
    parameter int DW = ssm_pkg::DATA_W
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [ssm_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [ssm_pkg::DATA_W-1:0]    reg_wdata,
    output logic      [ssm_pkg::DATA_W-1:0]    reg_rdata,
    output logic                               reg_rvalid,
    input  wire logic                          single_mode,
    input  wire logic [ssm_pkg::CAL_KINDS-1:0] cal_done,
    input  wire logic                          hours_tick,
    output logic                               meas_start,
    output logic      [15:0]                   hours_value
);
    import ssm_pkg::*;

    // ********************************
    // address mapping
    // ********************************
    function automatic logic [7:0] map_addr(input logic [7:0] a);
        logic [7:0] r;
        r = a;
        unique case (a)
            8'hC0: r = ADR_PRIM_C0;
            8'hC1: r = ADR_PRIM_C1;
            8'hC2: r = ADR_PRIM_C2;
            8'hC3: r = ADR_PRIM_C3;
            default: begin
                if (a >= ADR_HOURS_HI && a <= MIR_LAST) begin
                    r = 8'(a - ADR_HOURS_HI + ADR_PRIM_C4);
                end
            end
        endcase
        return r;
    endfunction

    // primary address of each locally held byte
    localparam logic [7:0] P_FLAGS = ADR_PRIM_C1;
    localparam logic [7:0] P_TRIG  = ADR_PRIM_C3;
    localparam logic [7:0] P_HR_HI = ADR_PRIM_C4;
    localparam logic [7:0] P_HR_LO = 8'(ADR_PRIM_C4 + 8'h01);

    function automatic logic is_rsvd(input logic [7:0] a);
        return (a == ADR_RSVD_C0) || (a == ADR_RSVD_C2) ||
               (a == ADR_PRIM_C0) || (a == ADR_PRIM_C2);
    endfunction

    function automatic logic is_local(input logic [7:0] a);
        return (a == P_FLAGS) || (a == P_TRIG) ||
               (a == P_HR_HI) || (a == P_HR_LO);
    endfunction

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [7:0]  flags;
        logic [15:0] hours;
        logic        start;
        logic        rvalid;
        logic        rd_local;
        logic [7:0]  local_data;
    } ssm_state_t;

    ssm_state_t st_reg;
    ssm_state_t st_next;

    logic      [7:0] wr_map;
    logic      [7:0] rd_map;
    logic            store_wr;
    logic      [7:0] store_q;
    logic            wr_flags;
    logic            wr_trig;
    logic            wr_hr_hi;
    logic            wr_hr_lo;
    logic            rd_flags;
    logic            rd_hr_hi;
    logic            rd_hr_lo;
    wire logic [7:0] cal_set;

    // ********************************
    // register port decode
    // ********************************
    assign wr_map   = map_addr(reg_addr);
    assign rd_map   = map_addr(reg_addr);
    assign wr_flags = reg_wr && (wr_map == P_FLAGS);
    assign wr_trig  = reg_wr && (wr_map == P_TRIG);
    assign wr_hr_hi = reg_wr && (wr_map == P_HR_HI);
    assign wr_hr_lo = reg_wr && (wr_map == P_HR_LO);
    assign rd_flags = (rd_map == P_FLAGS);
    assign rd_hr_hi = (rd_map == P_HR_HI);
    assign rd_hr_lo = (rd_map == P_HR_LO);

    // local bytes and reserved bytes bypass the store
    assign store_wr = reg_wr && !is_rsvd(wr_map) && !is_local(wr_map);

    // ********************************
    // calibration flag set vector
    // ********************************
    for (genvar g = 0; g < 8; g++) begin : g_cal_set
        if (g >= CAL_BIT_FACTORY && g < CAL_BIT_FACTORY + CAL_KINDS) begin : g_kind
            assign cal_set[g] = cal_done[g - CAL_BIT_FACTORY];
        end else begin : g_none
            assign cal_set[g] = 1'b0;
        end
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        st_next            = st_reg;
        st_next.start      = 1'b0;
        st_next.rvalid     = reg_rd;
        st_next.rd_local   = 1'b0;
        st_next.local_data = RESET_BYTE;
        // host write, then hardware set wins over clear
        if (wr_flags) begin
            st_next.flags = reg_wdata & CAL_FLAG_MASK;
        end
        st_next.flags = st_next.flags | cal_set;
        if (wr_trig && single_mode) begin
            st_next.start = 1'b1;
        end
        // tick first, so a byte write in the same cycle wins for its byte
        if (hours_tick) begin
            st_next.hours = 16'(st_reg.hours + 16'h0001);
        end
        if (wr_hr_hi) begin
            st_next.hours[15:8] = reg_wdata;
        end
        if (wr_hr_lo) begin
            st_next.hours[7:0] = reg_wdata;
        end
        if (reg_rd) begin
            st_next.rd_local = is_local(rd_map) || is_rsvd(rd_map);
            if (rd_flags) begin
                st_next.local_data = st_reg.flags;
            end else if (rd_hr_hi) begin
                st_next.local_data = st_reg.hours[15:8];
            end else if (rd_hr_lo) begin
                st_next.local_data = st_reg.hours[7:0];
            end else begin
                st_next.local_data = RESET_BYTE;
            end
        end
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '{flags: RESET_BYTE, hours: HOURS_RESET, start: 1'b0,
                        rvalid: 1'b0, rd_local: 1'b0, local_data: RESET_BYTE};
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************************
    // backing store
    // ********************************
    ssm_store #(
        .AW (AW),
        .DW (DW)
    ) u_store (
        .clk_sys (clk_sys),
        .wr_en   (store_wr),
        .wr_addr (wr_map),
        .wr_data (reg_wdata),
        .rd_addr (rd_map),
        .rd_data (store_q)
    );

    // ********************************
    // outputs
    // ********************************
    assign reg_rdata   = !st_reg.rvalid ? RESET_BYTE :
                         (st_reg.rd_local ? st_reg.local_data : store_q);
    assign reg_rvalid  = st_reg.rvalid;
    assign meas_start  = st_reg.start;
    assign hours_value = st_reg.hours;
endmodule // ssm_regs

//--- core/ssm_store.sv
// Purpose: byte memory backing the read/write registers
// Assumes: one write port, one read port, registered read data
// Notes:   contents undefined until written
`timescale 1ns/10ps
module ssm_store #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // ssm_store

//--- test/ssm_host.sv
// Purpose: host controller model on the byte register port
// Assumes: requests start 1ns after the rising edge
// Notes:   keeps its own hours copy across power-down
`timescale 1ns/10ps
module ssm_host (
    input  wire logic       clk_sys,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    output logic [7:0]      reg_addr = 8'h00,
    output logic [7:0]      reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    logic [15:0] hrs_copy;
    logic [7:0]  par_copy [8];
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge clk_sys);
        #1 {reg_wr, reg_wdata} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge clk_sys);
        #1 reg_rd = 1'b0;
        d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask
    task automatic save_hours(input logic [15:0] n);
        rd(8'hC4, hrs_copy[15:8]);
        rd(8'hC5, hrs_copy[7:0]);
        hrs_copy = hrs_copy + n;
    endtask
    task automatic restore_hours();
        wr(8'hC4, hrs_copy[15:8]);
        wr(8'hC5, hrs_copy[7:0]);
    endtask
    task automatic save_params();
        for (int k = 0; k < 8; k++) begin
            rd(8'(8'hC6 + k), par_copy[k]);
        end
    endtask
    task automatic restore_params();
        for (int k = 0; k < 8; k++) begin
            wr(8'(8'hC6 + k), par_copy[k]);
        end
    endtask
endmodule // ssm_host

//--- test/ssm_regs_asserts.sv
// Purpose: port checks on the mirror register block
// Assumes: one clock, async high reset
// Notes:   bound to every ssm_regs
`timescale 1ns/10ps
module ssm_regs_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        single_mode,
    input wire logic [4:0]  cal_done,
    input wire logic        hours_tick,
    input wire logic        meas_start,
    input wire logic [15:0] hours_value
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
        else $error("read unanswered");
    AST_RD_QUIET: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
        else $error("stray read data");
    AST_RSVD_ZERO: assert property (reg_rd && (reg_addr == 8'hC0 || reg_addr == 8'hC2)
        |=> reg_rdata == 8'h00) else $error("reserved not zero");
    AST_FLAG_SET: assert property (cal_done[4] ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'hC1)
        |=> reg_rdata[6]) else $error("flag not set");
    AST_TRIG_GO: assert property (reg_wr && single_mode && (reg_addr == 8'hC3
        || reg_addr == 8'h93) |=> meas_start) else $error("no start");
    AST_TRIG_MODE: assert property (!single_mode |=> !meas_start)
        else $error("start outside single mode");
    AST_HOURS_HOLD: assert property (!reg_wr && !hours_tick |=> $stable(hours_value))
        else $error("hours moved");
    AST_HOURS_TICK: assert property (hours_tick && !reg_wr
        |=> hours_value == $past(hours_value) + 16'h0001) else $error("hours not stepped");
endmodule // ssm_regs_asserts
bind ssm_regs ssm_regs_asserts chk_u (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .single_mode, .cal_done, .hours_tick, .meas_start, .hours_value);

//--- test/tb_single_shot_mirror_registers.sv
// Purpose: self-checking bench for the mirror register block
// Assumes: inputs driven 1ns after the rising edge
// Notes:   host model drives the register port
`timescale 1ns/10ps
module tb_single_shot_mirror_registers;
    logic        clk_sys, rst, reg_wr, reg_rd, reg_rvalid, single_mode, hours_tick, meas_start;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic [4:0]  cal_done;
    logic [15:0] hours_value;
    int          error_cnt = 0;
    int          tests_run = 0;
    // write addr, read addr, data, expected
    logic [31:0] rows [8] = '{32'hC68A5555, 32'h8BC7A3A3, 32'hCD913C3C, 32'hC4881212,
                              32'h81C1FF7C, 32'hC0C0FF00, 32'h92C2FF00, 32'hC3C30100};
    ssm_regs dut_u (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .single_mode, .cal_done, .hours_tick, .meas_start, .hours_value);
    ssm_host host_u (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h exp %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #20000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        {rst, single_mode, cal_done, hours_tick} = {1'b1, 1'b0, 5'h00, 1'b0};
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        chk(hours_value, 16'h0000);
        chk(meas_start, 16'h0000);
        chk(reg_rvalid, 16'h0000);
        chk(reg_rdata, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            host_u.wr(rows[i][31:24], rows[i][15:8]);
            host_u.rd(rows[i][23:16], d);
            chk(d, rows[i][7:0]);
        end
        for (int m = 0; m < 4; m++) begin
            single_mode = m[0];
            host_u.wr(m[1] ? 8'h93 : 8'hC3, 8'h01);
            chk(meas_start, m[0]);
        end
        @(posedge clk_sys);
        #1 chk(meas_start, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            host_u.wr(8'hC1, 8'h00);
            cal_done = 5'h01 << i;
            @(posedge clk_sys);
            #1 cal_done = 5'h00;
            host_u.rd(8'hC1, d);
            chk(d, 8'h04 << i);
            host_u.rd(8'h81, d);
            chk(d, 8'h04 << i);
        end
        fork
            host_u.wr(8'hC1, 8'h00);
            begin
                @(posedge clk_sys);
                #1 cal_done = 5'h01;
                @(posedge clk_sys);
                #1 cal_done = 5'h00;
            end
        join
        host_u.rd(8'hC1, d);
        chk(d, 16'h0004);
        host_u.wr(8'hC4, 8'h00);
        host_u.wr(8'hC5, 8'hFF);
        hours_tick = 1'b1;
        @(posedge clk_sys);
        #1 hours_tick = 1'b0;
        chk(hours_value, 16'h0100);
        for (int k = 0; k < 8; k++) begin
            host_u.wr(8'(8'hC6 + k), 8'(8'h30 + k));
        end
        host_u.save_hours(16'h0005);
        host_u.save_params();
        rst = 1'b1;
        #20 rst = 1'b0;
        chk(hours_value, 16'h0000);
        host_u.rd(8'hC1, d);
        chk(d, 16'h0000);
        host_u.restore_hours();
        chk(hours_value, 16'h0105);
        host_u.restore_params();
        host_u.wr(8'hC3, 8'h01);
        chk(meas_start, 16'h0001);
        for (int k = 0; k < 8; k++) begin
            host_u.rd(8'(8'h8A + k), d);
            chk(d, 16'(8'h30 + k));
        end
        end_of_test();
    end
endmodule // tb_single_shot_mirror_registers
